// *** logic/ccpu_pkg.sv ***
/*
  constants, register offsets and carrier types of the compare/PWM channel.
  assumes a 32-bit apb slave; each register takes one aligned word.
*/
package ccpu_pkg;
  // register byte offsets
  localparam logic [7:0] CCPU_OFF_CONTROL = 8'h00;
  localparam logic [7:0] CCPU_OFF_VALUE_LOW = 8'h04;
  localparam logic [7:0] CCPU_OFF_VALUE_HIGH = 8'h08;
  localparam logic [7:0] CCPU_OFF_TIMER_SEL = 8'h0C;
  localparam logic [7:0] CCPU_OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] CCPU_OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] CCPU_OFF_PIN_STATE = 8'h18;
  // control field positions
  localparam int CCPU_MODE_LSB = 0;
  localparam int CCPU_DUTY_LSB = 4;
  // reset values
  localparam logic [7:0] CCPU_CONTROL_RST = 8'h00;
  localparam logic [7:0] CCPU_BYTE_RST = 8'h00;
  // mode field encodings
  localparam logic [3:0] CCPU_MODE_OFF = 4'h0;
  localparam logic [3:0] CCPU_MODE_TOGGLE = 4'h2;
  localparam logic [3:0] CCPU_MODE_SET_HI = 4'h8;
  localparam logic [3:0] CCPU_MODE_SET_LO = 4'h9;
  localparam logic [3:0] CCPU_MODE_SWIRQ = 4'hA;
  localparam logic [1:0] CCPU_MODE_PWM_TOP = 2'h3;

  // decoded mode classes
  typedef enum logic [2:0] {
    CCPU_CLS_IDLE = 3'b000,
    CCPU_CLS_TOGGLE = 3'b001,
    CCPU_CLS_HIGH = 3'b010,
    CCPU_CLS_LOW = 3'b011,
    CCPU_CLS_SWIRQ = 3'b100,
    CCPU_CLS_PWM = 3'b101
  } ccpu_class_e;

  // timer inputs seen by the channel
  typedef struct packed {
    logic [15:0] first_timer_count;
    logic [15:0] third_timer_count;
    logic [7:0] pwm_timer_count;
    logic [7:0] pwm_period_value;
    logic [1:0] pwm_phase;
    logic pwm_tick;
  } ccpu_timers_s;

  // whole channel state
  typedef struct packed {
    logic [7:0] control_reg;
    logic [7:0] value_low_reg;
    logic [7:0] value_high_reg;
    logic timer_sel_reg;
    logic match_flag_reg;
    logic irq_enable_reg;
    logic out_latch_reg;
    logic equal_reg;
    logic [1:0] duty_latch_reg;
    logic pwm_wrap_reg;
    logic [31:0] prdata_reg;
  } ccpu_state_s;
endpackage

// *** logic/ccpu_compare_pwm.sv ***
/*
  one standard compare/PWM channel behind an apb slave.
  assumes timers come from logic on pclk; pin direction is handled outside.
*/
// Summary of operation
// RL1: compare mode checks 16-bit value against first or third timer.
// RL2: on match drive high, low, toggle, or leave pin following port latch.
// RL3: match flag sets in same cycle as pin action.
// RL4: software interrupt mode leaves pin alone; interrupt gated by enable bit.
// RL5: writing zero to control forces channel output latch low.
// RL6: software runs compare timer in timer or synchronized counter mode.
// RL7: software sets pin direction to output; channel never changes it.
// RL8: software clears control before writing new prescale mode.
// RL9: PWM mode produces output with up to ten bits duty resolution.
// RL10: two low duty bits kept in separate 2-bit latch.
// RL11: PWM cycle length comes from period register alone; high time within it comes from duty.
// RL12: mode field decodes off, toggle, set high, set low, interrupt, PWM.
// RL13: at period end timer clears, pin sets unless duty zero, duty reloads.
// RL14: pin clears when buffered duty equals timer count with two phase bits.
// RL15: match event fires once when equality first appears, not while held.
`timescale 1ns/1ps
module ccpu_compare_pwm
  import ccpu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ccpu_timers_s timers,
  input wire logic port_latch,
  output logic pwm_timer_clear,
  output logic channel_output_pin,
  output logic irq
);

  ccpu_state_s st_reg;
  ccpu_state_s st_next;
  ccpu_class_e cls;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [15:0] cmp_count;
  logic now_equal;
  logic match_evt;
  logic [9:0] duty_new;
  logic [9:0] duty_buf;
  logic [9:0] pwm_count_ext;

  // mode field to behaviour class
  // RL12: mode decode table
  function automatic ccpu_class_e decode_mode(input logic [3:0] m);
    ccpu_class_e c;
    c = CCPU_CLS_IDLE;
    if (m[3:2] == CCPU_MODE_PWM_TOP) begin
      c = CCPU_CLS_PWM;
    end else begin
      case (m)
        CCPU_MODE_TOGGLE: c = CCPU_CLS_TOGGLE;
        CCPU_MODE_SET_HI: c = CCPU_CLS_HIGH;
        CCPU_MODE_SET_LO: c = CCPU_CLS_LOW;
        CCPU_MODE_SWIRQ: c = CCPU_CLS_SWIRQ;
        default: c = CCPU_CLS_IDLE;
      endcase
    end
    return c;
  endfunction

  // byte lane merge for a write
  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d, input logic s);
    return s ? d[7:0] : old;
  endfunction

  // apb decode; zero wait states
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  always_comb begin
    case (paddr)
      CCPU_OFF_CONTROL, CCPU_OFF_VALUE_LOW, CCPU_OFF_VALUE_HIGH, CCPU_OFF_TIMER_SEL,
      CCPU_OFF_IRQ_STATUS, CCPU_OFF_IRQ_MASK, CCPU_OFF_PIN_STATE: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // compare source and edge of equality
  assign cls = decode_mode(st_reg.control_reg[CCPU_MODE_LSB +: 4]);
  // RL1: timer select and compare
  assign cmp_count = st_reg.timer_sel_reg ? timers.third_timer_count : timers.first_timer_count;
  assign now_equal = (cmp_count == {st_reg.value_high_reg, st_reg.value_low_reg});
  // RL15: first cycle of equality only
  assign match_evt = now_equal && !st_reg.equal_reg &&
                     (cls inside {CCPU_CLS_TOGGLE, CCPU_CLS_HIGH, CCPU_CLS_LOW, CCPU_CLS_SWIRQ});

  // pwm duty values
  assign duty_new = {st_reg.value_low_reg, st_reg.control_reg[CCPU_DUTY_LSB +: 2]};
  // RL10: separate two-bit latch
  assign duty_buf = {st_reg.value_high_reg, st_reg.duty_latch_reg};
  // RL14: count extended by phase bits
  assign pwm_count_ext = {timers.pwm_timer_count, timers.pwm_phase};
  // RL11: period end from period register
  assign pwm_timer_clear = (cls == CCPU_CLS_PWM) && timers.pwm_tick &&
                           (timers.pwm_timer_count == timers.pwm_period_value);

  // next state
  always_comb begin
    st_next = st_reg;
    st_next.equal_reg = now_equal;
    // read data stands until the next read setup, so the access edge sees it
    st_next.prdata_reg = st_reg.prdata_reg;
    // compare actions
    if (match_evt) begin
      // RL3: flag with pin action
      st_next.match_flag_reg = 1'b1;
      // RL2: pin action per mode
      case (cls)
        CCPU_CLS_TOGGLE: st_next.out_latch_reg = !st_reg.out_latch_reg;
        CCPU_CLS_HIGH: st_next.out_latch_reg = 1'b1;
        CCPU_CLS_LOW: st_next.out_latch_reg = 1'b0;
        // RL4: pin untouched
        default: st_next.out_latch_reg = st_reg.out_latch_reg;
      endcase
    end
    // pwm period and duty
    // RL9: pwm output mode
    if (cls == CCPU_CLS_PWM) begin
      st_next.pwm_wrap_reg = pwm_timer_clear;
      if (st_reg.pwm_wrap_reg) begin
        // RL13: reload duty, set pin
        st_next.value_high_reg = st_reg.value_low_reg;
        st_next.duty_latch_reg = st_reg.control_reg[CCPU_DUTY_LSB +: 2];
        st_next.out_latch_reg = (duty_new != 10'h000);
      end else if (duty_buf == pwm_count_ext) begin
        // RL14: clear at duty match
        st_next.out_latch_reg = 1'b0;
      end
    end else begin
      st_next.pwm_wrap_reg = 1'b0;
    end
    // register writes
    if (wr_en && addr_ok) begin
      case (paddr)
        CCPU_OFF_CONTROL: begin
          if (pstrb[0]) begin
            st_next.control_reg = {2'b00, pwdata[5:0]};
            // RL5: zero write clears latch
            if (pwdata[5:0] == 6'h00) begin
              st_next.out_latch_reg = 1'b0;
            end else if (pwdata[3:0] == CCPU_MODE_SET_HI) begin
              st_next.out_latch_reg = 1'b0;
            end else if (pwdata[3:0] == CCPU_MODE_SET_LO) begin
              st_next.out_latch_reg = 1'b1;
            end
          end
        end
        CCPU_OFF_VALUE_LOW: st_next.value_low_reg = merge_byte(st_reg.value_low_reg, pwdata, pstrb[0]);
        CCPU_OFF_VALUE_HIGH: begin
          if (cls != CCPU_CLS_PWM) begin
            st_next.value_high_reg = merge_byte(st_reg.value_high_reg, pwdata, pstrb[0]);
          end
        end
        CCPU_OFF_TIMER_SEL: begin
          if (pstrb[0]) begin
            st_next.timer_sel_reg = pwdata[0];
          end
        end
        CCPU_OFF_IRQ_STATUS: begin
          // write one clears; a same-cycle match wins
          if (pstrb[0] && pwdata[0] && !match_evt) begin
            st_next.match_flag_reg = 1'b0;
          end
        end
        CCPU_OFF_IRQ_MASK: begin
          if (pstrb[0]) begin
            st_next.irq_enable_reg = pwdata[0];
          end
        end
        default: st_next.prdata_reg = st_reg.prdata_reg;
      endcase
    end
    // read data captured in setup phase
    if (rd_en) begin
      case (paddr)
        CCPU_OFF_CONTROL: st_next.prdata_reg = {24'h00_0000, st_reg.control_reg};
        CCPU_OFF_VALUE_LOW: st_next.prdata_reg = {24'h00_0000, st_reg.value_low_reg};
        CCPU_OFF_VALUE_HIGH: st_next.prdata_reg = {24'h00_0000, st_reg.value_high_reg};
        CCPU_OFF_TIMER_SEL: st_next.prdata_reg = {31'h0000_0000, st_reg.timer_sel_reg};
        CCPU_OFF_IRQ_STATUS: st_next.prdata_reg = {31'h0000_0000, st_reg.match_flag_reg};
        CCPU_OFF_IRQ_MASK: st_next.prdata_reg = {31'h0000_0000, st_reg.irq_enable_reg};
        CCPU_OFF_PIN_STATE: st_next.prdata_reg = {31'h0000_0000, st_reg.out_latch_reg};
        default: st_next.prdata_reg = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign prdata = st_reg.prdata_reg;
  // RL4: software interrupt mode follows port latch
  assign channel_output_pin = (cls == CCPU_CLS_SWIRQ || cls == CCPU_CLS_IDLE && st_reg.control_reg == 8'h00)
                              ? (cls == CCPU_CLS_SWIRQ ? port_latch : st_reg.out_latch_reg)
                              : st_reg.out_latch_reg;
  // RL4: interrupt gated by enable
  assign irq = st_reg.match_flag_reg && st_reg.irq_enable_reg;

endmodule

// *** testbench/ccpu_asserts.sv ***
/*
  port checker for the compare/pwm channel.
  assumes it is bound to ccpu_compare_pwm.
*/
`timescale 1ns/1ps
module ccpu_asserts
  import ccpu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire ccpu_timers_s timers,
  input wire logic port_latch,
  input wire logic pwm_timer_clear,
  input wire logic channel_output_pin,
  input wire logic irq
);
  logic [3:0] mode_q;
  logic mask_q;
  wire wr = psel && penable && pwrite;
  // mirror of mode and mask as software writes them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 4'h0;
      mask_q <= 1'b0;
    end else if (wr && paddr == CCPU_OFF_CONTROL) begin
      mode_q <= pwdata[3:0];
    end else if (wr && paddr == CCPU_OFF_IRQ_MASK) begin
      mask_q <= pwdata[0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_zero_ctrl;
    wr && paddr == CCPU_OFF_CONTROL && pwdata[7:0] == 8'h00;
  endsequence
  a_ready_always: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (psel && penable && paddr > CCPU_OFF_PIN_STATE |-> pslverr) else $error("no slverr");
  a_zero_ctrl_low: assert property (s_zero_ctrl |=> !channel_output_pin) else $error("pin not low");
  a_clear_cause: assert property (pwm_timer_clear |-> timers.pwm_tick &&
    timers.pwm_timer_count == timers.pwm_period_value) else $error("bad timer clear");
  a_clear_pwm_only: assert property (mode_q[3:2] != CCPU_MODE_PWM_TOP |-> !pwm_timer_clear) else $error("clear");
  a_swirq_port: assert property (mode_q == CCPU_MODE_SWIRQ |-> channel_output_pin == port_latch) else $error("pin");
  a_irq_masked: assert property (!mask_q |-> !irq) else $error("irq while masked");
  a_high_no_fall: assert property (mode_q == CCPU_MODE_SET_HI && $past(mode_q) == CCPU_MODE_SET_HI
    |-> !$fell(channel_output_pin)) else $error("pin fell");
  a_low_no_rise: assert property (mode_q == CCPU_MODE_SET_LO && $past(mode_q) == CCPU_MODE_SET_LO
    |-> !$rose(channel_output_pin)) else $error("pin rose");
endmodule
bind ccpu_compare_pwm ccpu_asserts u_chk (.*);

// *** testbench/ccpu_load_model.sv ***
/*
  external load on the channel pin.
  assumes a clean level sampled on pclk.
*/
`timescale 1ns/1ps
module ccpu_load_model (
  input wire logic pclk,
  input wire logic level,
  input wire logic clear,
  output logic [15:0] high_cnt
);
  // count cycles in which the load is driven high
  // sampled on the falling edge, where the pin has settled
  always @(negedge pclk) begin
    if (clear) begin
      high_cnt <= 16'h0000;
    end else if (level === 1'b1) begin
      high_cnt <= high_cnt + 16'h0001;
    end
  end
endmodule

// *** testbench/ccp_compare_pwm_unit_bench.sv ***
/*
  self-checking bench of the compare/pwm channel.
  assumes zero wait state apb and a pwm timer modelled here.
*/
`timescale 1ns/1ps
module ccp_compare_pwm_unit_bench;
  import ccpu_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, port_latch = 0, ld_clr = 0, err;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, prdata;
  logic [15:0] high_cnt, h6, h7, h0;
  logic pready, pslverr, pwm_timer_clear, pin, irq;
  logic pin_s = 0, irq_s = 0, clr_s = 0;
  ccpu_timers_s tm = '0;
  int error_cnt = 0, tests_run = 0;
  ccpu_compare_pwm uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timers(tm), .port_latch(port_latch), .pwm_timer_clear(pwm_timer_clear), .channel_output_pin(pin), .irq(irq));
  ccpu_load_model load (.pclk(pclk), .level(pin), .clear(ld_clr), .high_cnt(high_cnt));
  // clock
  initial begin
    forever #20 pclk = ~pclk;
  end
  // outputs snapshot at the falling edge, read at the next rising edge
  always @(negedge pclk) begin
    pin_s <= pin;
    irq_s <= irq;
    clr_s <= pwm_timer_clear;
  end
  // pwm timer: phase every cycle, count steps on phase wrap
  // timers run synchronous to pclk
  // pin taken as an output throughout
  always @(posedge pclk) begin
    tm.pwm_period_value <= 8'h03;
    tm.pwm_phase <= tm.pwm_phase + 2'h1;
    tm.pwm_tick <= (tm.pwm_phase == 2'h2);
    if (tm.pwm_tick) begin
      tm.pwm_timer_count <= pwm_timer_clear ? 8'h00 : tm.pwm_timer_count + 8'h01;
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic t_regs();
    apb(1'b0, CCPU_OFF_CONTROL, 32'h0000_0000);
    chk("control reset", 32'h0000_0000, rd);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0, err});
  endtask
  task automatic t_high();
    apb(1'b1, CCPU_OFF_IRQ_MASK, 32'h0000_0001);
    apb(1'b1, CCPU_OFF_VALUE_LOW, 32'h0000_0034);
    apb(1'b1, CCPU_OFF_VALUE_HIGH, 32'h0000_0012);
    apb(1'b1, CCPU_OFF_CONTROL, 32'h0000_0008);
    tm.third_timer_count <= 16'h1234;
    repeat (3) @(posedge pclk);
    chk("wrong timer", 32'h0000_0000, {irq_s, pin_s});
    tm.first_timer_count <= 16'h1234;
    @(posedge pclk);
    chk("before action", 32'h0000_0000, {irq_s, pin_s});
    @(posedge pclk);
    chk("pin and irq", 32'h0000_0003, {irq_s, pin_s});
    apb(1'b1, CCPU_OFF_IRQ_STATUS, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk("no second match", 32'h0000_0000, {31'h0, irq_s});
  endtask
  task automatic t_swirq();
    apb(1'b1, CCPU_OFF_IRQ_MASK, 32'h0000_0000);
    apb(1'b1, CCPU_OFF_TIMER_SEL, 32'h0000_0001);
    tm.third_timer_count <= 16'h0000;
    port_latch <= 1'b1;
    apb(1'b1, CCPU_OFF_CONTROL, 32'h0000_000A);
    tm.third_timer_count <= 16'h1234;
    repeat (3) @(posedge pclk);
    chk("swirq pin irq", 32'h0000_0001, {irq_s, pin_s});
    apb(1'b0, CCPU_OFF_IRQ_STATUS, 32'h0000_0000);
    chk("third timer flag", 32'h0000_0001, {31'h0, rd[0]});
    apb(1'b1, CCPU_OFF_IRQ_STATUS, 32'h0000_0001);
    port_latch <= 1'b0;
  endtask
  task automatic t_toggle();
    tm.third_timer_count <= 16'h0000;
    // clear control before a new mode
    apb(1'b1, CCPU_OFF_CONTROL, 32'h0000_0000);
    apb(1'b1, CCPU_OFF_CONTROL, 32'h0000_0002);
    for (int i = 0; i < 3; i++) begin
      tm.third_timer_count <= 16'h1234;
      repeat (5) @(posedge pclk);
      chk("toggle", {31'h0, ~i[0]}, {31'h0, pin_s});
      tm.third_timer_count <= 16'h0000;
      @(posedge pclk);
    end
    apb(1'b1, CCPU_OFF_CONTROL, 32'h0000_0000);
    @(posedge pclk);
    chk("zero control", 32'h0000_0000, {31'h0, pin_s});
  endtask
  task automatic pwm_high(input logic [3:0] md, input logic [9:0] duty, output logic [15:0] hc);
    int n;
    apb(1'b1, CCPU_OFF_VALUE_LOW, {24'h0, duty[9:2]});
    apb(1'b1, CCPU_OFF_CONTROL, {26'h0, duty[1:0], md});
    for (int k = 0; k < 2; k++) begin
      n = 0;
      @(posedge pclk);
      while (clr_s !== 1'b1 && n < 2000) begin
        @(posedge pclk);
        n++;
      end
    end
    ld_clr <= 1'b1;
    @(posedge pclk);
    ld_clr <= 1'b0;
    repeat (16) @(posedge pclk);
    hc = high_cnt;
  endtask
  task automatic t_pwm();
    pwm_high(4'hC, 10'h006, h6);
    pwm_high(4'hF, 10'h007, h7);
    pwm_high(4'hD, 10'h000, h0);
    chk("duty width", 32'h0000_0001, {31'h0, h6 >= 16'h0006 && h6 <= 16'h0007});
    chk("duty low bits", 32'h0000_0001, {16'h0, h7 - h6});
    chk("duty zero", 32'h0000_0000, {16'h0, h0});
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #(40 * 20000);
    error_cnt++;
    end_of_test();
  end
  // main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_high();
    t_swirq();
    t_toggle();
    t_pwm();
    end_of_test();
  end
endmodule
